// ---- rtl/prs_pkg.sv ----
// Constants, register indices and carrier types for the processor reset sequencer.
// Assumes a single 20 MHz clock and a plain word-indexed register port.
package prs_pkg;

   // Register indices on the plain register port (one 32-bit word each)
   localparam logic [3:0] REG_IRQ_MASK   = 4'h0;
   localparam logic [3:0] REG_IRQ_FLAG   = 4'h1;
   localparam logic [3:0] REG_IO_FLAG    = 4'h2;
   localparam logic [3:0] REG_CPU_FLAGS  = 4'h3;
   localparam logic [3:0] REG_PERIPH_CTL = 4'h4;
   localparam logic [3:0] REG_STRB_A_CTL = 4'h5;
   localparam logic [3:0] REG_STRB_B_CTL = 4'h6;
   localparam logic [3:0] REG_PC         = 4'h7;
   localparam logic [3:0] REG_SEQ_STAT   = 4'h8;

   // Field positions
   localparam int unsigned CPU_FLAGS_WIDTH_BIT = 16;
   localparam int unsigned UF0_DIR_BIT         = 1;
   localparam int unsigned UF0_OUT_BIT         = 2;
   localparam int unsigned UF0_IN_BIT          = 3;
   localparam int unsigned UF1_DIR_BIT         = 5;
   localparam int unsigned UF1_OUT_BIT         = 6;
   localparam int unsigned UF1_IN_BIT          = 7;

   // Values after reset, the I/O flag write mask and the reset-vector address
   localparam logic [31:0] IRQ_MASK_RST    = 32'h0000_0000;
   localparam logic [31:0] IRQ_FLAG_RST    = 32'h0000_0000;
   localparam logic [31:0] IO_FLAG_RST     = 32'h0000_0000;
   localparam logic [31:0] CPU_FLAGS_RST   = 32'h0000_0000;
   localparam logic [31:0] IO_FLAG_WMASK   = 32'h0000_0066;
   localparam logic [31:0] PERIPH_CTL_RST  = 32'h0000_00F8;
   localparam logic [31:0] STRB_W32_CTL    = 32'h000F_10F8;
   localparam logic [31:0] STRB_W16_CTL    = 32'h0005_10F8;
   localparam logic [23:0] RESET_VEC_ADDR  = 24'h00_0000;
   localparam logic [23:0] PC_RST          = 24'h00_0000;
   localparam logic [1:0]  RST_SYNC_RST    = 2'h0;

   // Reset-vector fetch sequence
   typedef enum logic [1:0] {
      SEQ_HOLD,
      SEQ_FETCH,
      SEQ_GAP,
      SEQ_RUN
   } prs_seq_t;

   // External bus pins, all strobes active low
   typedef struct packed {
      logic [31:0] data_out;
      logic        data_oe;
      logic [23:0] addr_out;
      logic        addr_oe;
      logic        read_write;
      logic        peripheral_strobe_n;
      logic [3:0]  memory_strobe_a_n;
      logic [3:0]  memory_strobe_b_n;
      logic        irq_acknowledge_n;
   } prs_bus_t;

   localparam prs_bus_t BUS_IDLE = '{
      data_out:            32'h0000_0000,
      data_oe:             1'b0,
      addr_out:            24'h00_0000,
      addr_oe:             1'b0,
      read_write:          1'b1,
      peripheral_strobe_n: 1'b1,
      memory_strobe_a_n:   4'hF,
      memory_strobe_b_n:   4'hF,
      irq_acknowledge_n:   1'b1
   };

   // Phase clock generator state
   typedef struct packed {
      logic phase_one;
      logic phase_two;
   } prs_phase_t;

   localparam prs_phase_t PHASE_RST = '{phase_one: 1'b0, phase_two: 1'b1};

endpackage

// ---- rtl/prs_phase_clk.sv ----
// Two-phase output clock generator: two opposite phases at half the core clock.
// Assumes the async active-low reset returns both phases to their initial state.
`timescale 1ns/1ps
module prs_phase_clk
   import prs_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   output      logic phase_one_clock,
   output      logic phase_two_clock
);

   prs_phase_t q;
   prs_phase_t d;

   // Toggle both phases each edge, always opposite
   always_comb begin
      d           = q;
      d.phase_one = ~q.phase_one;
      d.phase_two = q.phase_one;
   end

   // Falling reset returns both phases to their start levels
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= PHASE_RST; // RULE11
      end else begin
         q <= d;
      end
   end

   assign phase_one_clock = q.phase_one;
   assign phase_two_clock = q.phase_two;

endmodule // prs_phase_clk

// ---- rtl/prs_reset_seq.sv ----
// Processor reset sequencer: reset state of core registers and pins, then reset-vector fetch.
// Assumes one 20 MHz clock, synchronous pin inputs and a one-cycle-latency register port.
//
// Operation
// RULE1 - Reset puts every modelled peripheral output back to its reset state.
// RULE2 - Interrupt mask, interrupt flag and I/O flag registers clear to zero.
// RULE3 - Core flags clear to zero except program-width bit, which copies the pin.
// RULE4 - Each external strobe control register loads its default value.
// RULE5 - After reset, one full-word read at address zero fetches the vector; in 16-bit mode the code makes two half-word reads.
// RULE6 - The fetched vector loads the program counter and execution starts there.
// RULE7 - Data and address buses go high impedance at reset.
// RULE8 - Read/write, all strobes and interrupt acknowledge are driven high at reset.
// RULE9 - User flag, serial and timer pins tristate asynchronously at reset.
// RULE10 - Ready, grant, width, interrupt, boot, clock, debug and tristate pins unaffected.
// RULE11 - Both phase clocks return to initial state when reset falls.
// RULE12 - Program-width pin high means 16-bit program memory, low means 32-bit.
// RULE13 - Strobes stay inactive while reset is low; the fetch starts after release.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module prs_reset_seq
   import prs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [31:0] data_in,
   input  wire logic        ready_n,
   input  wire logic        program_width_pin,
   input  wire logic [3:0]  ext_irq_pins_n,
   input  wire logic [1:0]  user_flag_in,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [31:0] reg_rdata,
   output      prs_bus_t    bus_pins,
   output      logic [1:0]  user_flag_out,
   output      logic [1:0]  user_flag_oe,
   output      logic [5:0]  serial_out,
   output      logic [5:0]  serial_oe,
   output      logic [1:0]  timer_out,
   output      logic [1:0]  timer_oe,
   output      logic [23:0] program_counter,
   output      logic        exec_running,
   output      logic        phase_one_clock,
   output      logic        phase_two_clock
);

   // Whole module state
   typedef struct packed {
      logic [1:0]  rst_sync;
      prs_seq_t    seq;
      logic        wide16;
      logic        half;
      prs_bus_t    bus;
      logic [31:0] irq_mask;
      logic [31:0] irq_flag;
      logic [31:0] io_flag;
      logic [31:0] cpu_flags;
      logic [31:0] periph_ctl;
      logic [31:0] strb_a_ctl;
      logic [31:0] strb_b_ctl;
      logic [31:0] vector;
      logic [23:0] pc;
      logic        running;
      logic [31:0] rdata;
      logic [1:0]  uf_out;
      logic [1:0]  uf_oe;
      logic [5:0]  ser_out;
      logic [5:0]  ser_oe;
      logic [1:0]  tmr_out;
      logic [1:0]  tmr_oe;
   } prs_state_t;

   localparam prs_state_t STATE_RST = '{
      rst_sync:   RST_SYNC_RST,
      seq:        SEQ_HOLD,
      wide16:     1'b0,
      half:       1'b0,
      bus:        BUS_IDLE,
      irq_mask:   IRQ_MASK_RST,
      irq_flag:   IRQ_FLAG_RST,
      io_flag:    IO_FLAG_RST,
      cpu_flags:  CPU_FLAGS_RST,
      periph_ctl: PERIPH_CTL_RST,
      strb_a_ctl: STRB_W32_CTL,
      strb_b_ctl: STRB_W32_CTL,
      vector:     32'h0000_0000,
      pc:         PC_RST,
      running:    1'b0,
      rdata:      32'h0000_0000,
      uf_out:     2'h0,
      uf_oe:      2'h0,
      ser_out:    6'h00,
      ser_oe:     6'h00,
      tmr_out:    2'h0,
      tmr_oe:     2'h0
   };

   prs_state_t q;
   prs_state_t d;

   // Byte-enable pattern of the vector read; in 16-bit mode the top pin is address line A_1
   function automatic logic [3:0] fetch_strobes(input logic wide16, input logic half);
      logic [3:0] s;
      s = 4'h0;
      if (wide16) begin
         s = half ? 4'hC : 4'h4;
      end
      return s;
   endfunction

   // Strobe control default follows the program memory width
   function automatic logic [31:0] strb_default(input logic wide16);
      return wide16 ? STRB_W16_CTL : STRB_W32_CTL; // RULE12
   endfunction

   // Bus pins with the vector read in progress
   function automatic prs_bus_t fetch_bus(input logic wide16, input logic half);
      prs_bus_t b;
      b                   = BUS_IDLE;
      b.addr_out          = RESET_VEC_ADDR;
      b.addr_oe           = 1'b1;
      b.read_write        = 1'b1;
      b.memory_strobe_a_n = fetch_strobes(wide16, half);
      return b;
   endfunction

   // Next-state logic
   always_comb begin
      d          = q;
      d.rst_sync = {q.rst_sync[0], 1'b1};
      d.rdata    = 32'h0000_0000;

      // Interrupt pins are only sampled here, never driven or reset
      for (int i = 0; i < 4; i++) begin
         if (reg_wr && reg_addr == REG_IRQ_FLAG && reg_wdata[i]) begin
            d.irq_flag[i] = 1'b0;
         end
         if (!ext_irq_pins_n[i]) begin
            d.irq_flag[i] = 1'b1; // RULE10
         end
      end

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            REG_IRQ_MASK: begin
               d.irq_mask = reg_wdata;
            end
            REG_IO_FLAG: begin
               d.io_flag = reg_wdata & IO_FLAG_WMASK;
            end
            REG_CPU_FLAGS: begin
               d.cpu_flags                      = reg_wdata;
               d.cpu_flags[CPU_FLAGS_WIDTH_BIT] = q.cpu_flags[CPU_FLAGS_WIDTH_BIT];
            end
            REG_PERIPH_CTL: begin
               d.periph_ctl = reg_wdata;
            end
            REG_STRB_A_CTL: begin
               d.strb_a_ctl = reg_wdata;
            end
            REG_STRB_B_CTL: begin
               d.strb_b_ctl = reg_wdata;
            end
            default: begin
            end
         endcase
      end

      // Register reads, data valid the next cycle
      if (reg_rd) begin
         unique case (reg_addr)
            REG_IRQ_MASK: begin
               d.rdata = q.irq_mask;
            end
            REG_IRQ_FLAG: begin
               d.rdata = q.irq_flag;
            end
            REG_IO_FLAG: begin
               d.rdata              = q.io_flag;
               d.rdata[UF0_IN_BIT]  = user_flag_in[0];
               d.rdata[UF1_IN_BIT]  = user_flag_in[1];
            end
            REG_CPU_FLAGS: begin
               d.rdata = q.cpu_flags;
            end
            REG_PERIPH_CTL: begin
               d.rdata = q.periph_ctl;
            end
            REG_STRB_A_CTL: begin
               d.rdata = q.strb_a_ctl;
            end
            REG_STRB_B_CTL: begin
               d.rdata = q.strb_b_ctl;
            end
            REG_PC: begin
               d.rdata = {8'h00, q.pc};
            end
            REG_SEQ_STAT: begin
               d.rdata = {28'h0000_000, q.wide16, q.running, q.seq};
            end
            default: begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end

      // User flag pins follow the I/O flag direction and value bits
      d.uf_oe  = {q.io_flag[UF1_DIR_BIT], q.io_flag[UF0_DIR_BIT]};
      d.uf_out = {q.io_flag[UF1_OUT_BIT], q.io_flag[UF0_OUT_BIT]};

      // Reset-vector fetch sequence
      unique case (q.seq)
         SEQ_HOLD: begin
            d.bus = BUS_IDLE; // RULE13
            d.cpu_flags[CPU_FLAGS_WIDTH_BIT] = program_width_pin; // RULE3
            d.strb_a_ctl = strb_default(program_width_pin); // RULE4
            d.strb_b_ctl = strb_default(program_width_pin); // RULE4
            if (q.rst_sync[1]) begin
               d.wide16 = program_width_pin; // RULE12
               d.half   = 1'b0;
               d.bus    = fetch_bus(program_width_pin, 1'b0); // RULE5
               d.seq    = SEQ_FETCH;
            end
         end
         SEQ_FETCH: begin
            if (!ready_n) begin
               d.bus = BUS_IDLE;
               if (q.wide16 && !q.half) begin
                  d.vector[15:0] = data_in[15:0]; // RULE5
                  d.half         = 1'b1;
                  d.seq          = SEQ_GAP;
               end else begin
                  if (q.wide16) begin
                     d.vector[31:16] = data_in[15:0];
                     d.pc            = {data_in[7:0], q.vector[15:0]}; // RULE6
                  end else begin
                     d.vector = data_in;
                     d.pc     = data_in[23:0]; // RULE6
                  end
                  d.running = 1'b1; // RULE6
                  d.seq     = SEQ_RUN;
               end
            end
         end
         SEQ_GAP: begin
            d.bus = fetch_bus(q.wide16, 1'b1); // RULE5
            d.seq = SEQ_FETCH;
         end
         SEQ_RUN: begin
            d.bus = BUS_IDLE;
         end
      endcase
   end

   // State register; every field takes its constant reset value
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= STATE_RST; // RULE1 RULE2 RULE7 RULE8 RULE9
      end else begin
         q <= d;
      end
   end

   // Phase clock generator
   prs_phase_clk u_phase (
      .clk             (clk),
      .reset_n         (reset_n),
      .phase_one_clock (phase_one_clock),
      .phase_two_clock (phase_two_clock)
   );

   // Outputs straight from the state register
   assign reg_rdata       = q.rdata;
   assign bus_pins        = q.bus;
   assign user_flag_out   = q.uf_out;
   assign user_flag_oe    = q.uf_oe;
   assign serial_out      = q.ser_out;
   assign serial_oe       = q.ser_oe;
   assign timer_out       = q.tmr_out;
   assign timer_oe        = q.tmr_oe;
   assign program_counter = q.pc;
   assign exec_running    = q.running;

endmodule // prs_reset_seq

// ---- sim/prs_reset_seq_props.sv ----
// Port assertions for the processor reset sequencer.
// Assumes one clock domain and binding onto prs_reset_seq.
`timescale 1ns/1ps
module prs_reset_seq_props
   import prs_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [31:0] data_in,
   input wire logic        ready_n,
   input wire logic        program_width_pin,
   input wire logic [1:0]  user_flag_oe,
   input wire logic [5:0]  serial_oe,
   input wire logic [1:0]  timer_oe,
   input wire prs_bus_t    bus_pins,
   input wire logic [23:0] program_counter,
   input wire logic        exec_running,
   input wire logic        phase_one_clock,
   input wire logic        phase_two_clock
);
   logic [23:0] vec_lo;
   logic [3:0]  strb_a;
   // Slices seen by the sampled-value functions
   assign vec_lo = data_in[23:0];
   assign strb_a = bus_pins.memory_strobe_a_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_BUS_RST: assert property (disable iff (1'b0) !reset_n |-> bus_pins == BUS_IDLE)
      else $error("bus not idle in reset");
   AST_TRI_RST: assert property (disable iff (1'b0) !reset_n |-> {user_flag_oe, serial_oe, timer_oe} == 10'h0)
      else $error("pin driven in reset");
   AST_PH_RST: assert property (disable iff (1'b0) !reset_n |-> !phase_one_clock && phase_two_clock)
      else $error("phase clocks not initial in reset");
   AST_PH_OPP: assert property (phase_one_clock != phase_two_clock)
      else $error("phase clocks not opposite");
   AST_PH_TGL: assert property ($past(reset_n) |-> phase_one_clock != $past(phase_one_clock))
      else $error("phase clock did not toggle");
   AST_HOLD_OFF: assert property ($rose(reset_n) |-> (bus_pins == BUS_IDLE) [*3])
      else $error("bus left idle too early");
   AST_FETCH_GO: assert property ($rose(reset_n) |-> ##3 bus_pins.addr_oe)
      else $error("vector fetch not started");
   AST_WIDTH: assert property ($rose(reset_n) |-> ##3 strb_a == (program_width_pin ? 4'h4 : 4'h0))
      else $error("first fetch strobes wrong for width");
   AST_FETCH_PIN: assert property (bus_pins.addr_oe |-> bus_pins.addr_out == 24'h0 && bus_pins.read_write)
      else $error("fetch not a read at zero");
   AST_FETCH_HOLD: assert property (bus_pins.addr_oe && ready_n |=> bus_pins.addr_oe && $stable(strb_a))
      else $error("fetch dropped before ready");
   AST_PC_LOAD: assert property ($rose(exec_running) && $past(strb_a) == 4'h0 |-> program_counter == $past(vec_lo))
      else $error("program counter not loaded with vector");
   AST_SINGLE: assert property (exec_running |=> exec_running && !bus_pins.addr_oe)
      else $error("fetch repeated after start");

   // Main scenarios
   cover property ($rose(exec_running));
   cover property ($rose(bus_pins.addr_oe) && strb_a == 4'hC);
   cover property (bus_pins.addr_oe && ready_n ##1 bus_pins.addr_oe);
endmodule // prs_reset_seq_props

bind prs_reset_seq prs_reset_seq_props u_props (.clk, .reset_n, .data_in, .ready_n, .program_width_pin,
   .user_flag_oe, .serial_oe, .timer_oe, .bus_pins, .program_counter, .exec_running, .phase_one_clock,
   .phase_two_clock);

// ---- sim/prs_mem_model.sv ----
// External memory holding the reset vector at address zero.
// Assumes strobe A selects it; answers after a set number of wait cycles.
`timescale 1ns/1ps
module prs_mem_model
   import prs_pkg::*;
(
   input  wire logic        clk,
   input  wire prs_bus_t    bus_pins,
   input  wire logic [31:0] vec,
   input  wire logic [3:0]  wait_cycles,
   output      logic [31:0] data_in,
   output      logic        ready_n
);
   logic [3:0]  cnt;
   logic [15:0] half;
   // Half word chosen by the A_1 pin on a 16-bit access
   assign half = bus_pins.memory_strobe_a_n[3] ? vec[31:16] : vec[15:0];
   initial begin
      cnt     = 4'h0;
      ready_n = 1'b1;
      data_in = 32'h0000_0000;
   end
   // Answer after the wait, released data toggles so stale values never match
   always @(posedge clk) begin
      if (bus_pins.addr_oe && bus_pins.memory_strobe_a_n != 4'hF) begin
         cnt <= cnt + 4'h1;
         if (cnt >= wait_cycles) begin
            ready_n <= 1'b0;
            data_in <= (bus_pins.memory_strobe_a_n == 4'h0) ? vec : {~half, half};
         end
      end else begin
         cnt     <= 4'h0;
         ready_n <= 1'b1;
         data_in <= ~data_in;
      end
   end
endmodule // prs_mem_model

// ---- sim/tb_top.sv ----
// Bench for the reset sequencer: reset pin states, vector fetch in both widths, register reset values.
// Assumes the memory model on the bus and the bound checker.
`timescale 1ns/1ps
module tb_top;
   import prs_pkg::*;
   logic        clk, reset_n, ready_n, program_width_pin, reg_wr, reg_rd, exec_running;
   logic        phase_one_clock, phase_two_clock;
   logic [31:0] data_in, reg_wdata, reg_rdata, vec;
   logic [3:0]  ext_irq_pins_n, reg_addr, wait_cycles;
   logic [1:0]  user_flag_in, user_flag_out, user_flag_oe, timer_out, timer_oe;
   logic [5:0]  serial_out, serial_oe;
   logic [23:0] program_counter;
   prs_bus_t    bus_pins;
   int          n_mismatch, cmp_count, cyc;

   prs_reset_seq DUT (.clk, .reset_n, .data_in, .ready_n, .program_width_pin, .ext_irq_pins_n, .user_flag_in,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_pins, .user_flag_out, .user_flag_oe, .serial_out,
      .serial_oe, .timer_out, .timer_oe, .program_counter, .exec_running, .phase_one_clock, .phase_two_clock);
   prs_mem_model u_mem (.clk, .bus_pins, .vec, .wait_cycles, .data_in, .ready_n);

   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic chk_reg(input string what, input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(what, reg_rdata, exp);
   endtask

   // Reset with a given width pin, then follow the vector fetch
   task automatic boot(input logic pgw, input logic [3:0] wt, input logic [31:0] v, input logic [31:0] strb);
      @(posedge clk);
      reset_n           <= 1'b0;
      program_width_pin <= pgw;
      wait_cycles       <= wt;
      vec               <= v;
      @(negedge clk);
      check("bus idle", 32'(bus_pins === BUS_IDLE), 32'h1);
      check("flag oe", user_flag_oe, 32'h0);
      check("port oe", {serial_oe, timer_oe}, 32'h0);
      check("port out", {serial_out, timer_out}, 32'h0);
      check("phases", {phase_one_clock, phase_two_clock}, 32'h1);
      repeat (11) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 60 && exec_running !== 1'b1; i++) @(posedge clk);
      #1 check("running", exec_running, 32'h1);
      check("pc", program_counter, v[23:0]);
      chk_reg("irq mask", REG_IRQ_MASK, 32'h0);
      chk_reg("irq flag", REG_IRQ_FLAG, 32'h0);
      chk_reg("io flag", REG_IO_FLAG, 32'h0);
      chk_reg("cpu flags", REG_CPU_FLAGS, 32'(pgw) << CPU_FLAGS_WIDTH_BIT);
      chk_reg("io strobe ctl", REG_PERIPH_CTL, PERIPH_CTL_RST);
      chk_reg("strobe a ctl", REG_STRB_A_CTL, strb);
      chk_reg("strobe b ctl", REG_STRB_B_CTL, strb);
      chk_reg("pc reg", REG_PC, {8'h00, v[23:0]});
      chk_reg("status", REG_SEQ_STAT, {28'h0, pgw, 3'h7});
   endtask

   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      reset_n = 1'b1;
      program_width_pin = 1'b0;
      ext_irq_pins_n = 4'hF;
      user_flag_in = 2'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      vec = 32'h0;
      wait_cycles = 4'h0;
      // Drop reset once every process waits, so the asynchronous clear lands before the first edge
      #1 reset_n = 1'b0;
      // Slow 32-bit fetch
      boot(1'b0, 4'h3, 32'hA5C3_1234, STRB_W32_CTL);
      // Dirty the registers and pins before a second reset
      wr_reg(REG_IRQ_MASK, 32'hFFFF_FFFF);
      wr_reg(REG_IO_FLAG, 32'hFFFF_FFFF);
      ext_irq_pins_n <= 4'h0;
      user_flag_in   <= 2'h3;
      @(posedge clk);
      ext_irq_pins_n <= 4'hF;
      repeat (2) @(posedge clk);
      #1 check("flag pins", {user_flag_oe, user_flag_out}, 32'hF);
      chk_reg("irq mask set", REG_IRQ_MASK, 32'hFFFF_FFFF);
      chk_reg("io flag set", REG_IO_FLAG, IO_FLAG_WMASK | (32'h1 << UF0_IN_BIT) | (32'h1 << UF1_IN_BIT));
      user_flag_in <= 2'h0;
      chk_reg("irq flag set", REG_IRQ_FLAG, 32'hF);
      chk_reg("unmapped", 4'hF, 32'h0);
      // Prompt 16-bit fetch after a mid-run reset
      boot(1'b1, 4'h0, 32'h003C_9A7E, STRB_W16_CTL);
      summarize();
   end
endmodule // tb_top
